// ---- pin_select_pkg.sv ----
package pin_select_pkg;

  // register byte offsets in the peripheral space; data sits in the low bits of the bus
  localparam logic [23:0] port_f_function_select_idx = 24'h100051;
  localparam logic [23:0] port_e_function_select_idx = 24'h100052;
  localparam int          addr_w                     = 26;
  localparam logic [25:0] port_f_addr                = {2'h0, port_f_function_select_idx};
  localparam logic [25:0] port_e_addr                = {2'h0, port_e_function_select_idx};

  // port e writable bits: 14,12,10,8,6,4,3..0
  localparam logic [15:0] pe_write_mask     = 16'h555f;
  localparam logic [15:0] pe_reset_master   = 16'h555f;
  localparam logic [15:0] pe_reset_single   = 16'h0000;
  localparam logic [7:0]  pf_write_mask     = 8'he0;
  localparam logic [7:0]  pf_reset_master   = 8'he0;
  localparam logic [7:0]  pf_reset_single   = 8'h00;

  // select bit positions in port e and port f; e1 and e0 give the low bit of their two-bit fields
  localparam int pe_e7_bit = 14;
  localparam int pe_e6_bit = 12;
  localparam int pe_e5_bit = 10;
  localparam int pe_e4_bit = 8;
  localparam int pe_e3_bit = 6;
  localparam int pe_e2_bit = 4;
  localparam int pe_e1_lsb = 2;
  localparam int pe_e0_lsb = 0;
  localparam int pf_f5_bit = 5;
  localparam int pf_f7_bit = 7;

  // two-bit field codes; both 0x codes mean gpio
  localparam logic [1:0] field_alt = 2'b10;
  localparam logic [1:0] field_pri = 2'b11;

  // pin function codes driven to the pad mux
  typedef enum logic [1:0] {
    fn_gpio      = 2'b00,
    fn_primary   = 2'b01,
    fn_alternate = 2'b10,
    fn_size      = 2'b11
  } pin_fn_e;

  typedef struct packed {
    logic [15:0] port_e_function_select;
    logic [7:0]  port_f_function_select;
    logic        ack;
    logic [31:0] rdata;
    logic        cfg_done;
    pin_fn_e [7:0] port_e_fn;
    logic [7:5]  f_addr;
    logic [7:5]  f_cs;
    logic [7:0]  e_gpio;
    logic [7:5]  f_gpio;
  } sel_state_s;

endpackage : pin_select_pkg

// ---- port_e_f_pin_function_select.sv ----
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/10ps
// Contract
// - e select bit 14 gives e7 to output-enable strobe, else gpio.
// - e select bit 12 gives e6 to transfer acknowledge input, else gpio.
// - e select bit 10 gives e5 to transfer error acknowledge, else gpio.
// - e select bit 8 gives e4 to read/write indicator, else gpio.
// - e select bit 6 gives e3 to timer sync a, else gpio.
// - e select bit 4 gives e2 to timer sync b, else gpio.
// - size functions on e3/e2 come only from the size-pins enable bit.
// - bits 3-2 pick e1: 0x gpio, 10 sync a, 11 transfer start.
// - bits 1-0 pick e0: 0x gpio, 10 sync b, 11 transfer in progress.
// - port e register read/write; odd bits 15..5 read zero, ignore writes.
// - reset loads ones and fields 11 in master mode, zeros in single-chip.
// - f select bit 7 gives f7 to address 23 or chip select six.
// - f select bit 6 gives f6 to address 22 or chip select five.
// - f select bit 5 gives f5 to address 21 or chip select four.
// - f bits 4-0 are reserved, read zero, reset zero.
// - f select bits reset to one in master mode, zero otherwise.
// - a pin on gpio is served by the port data logic, not the peripheral.
module port_e_f_pin_function_select (
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  input  wire logic [25:0]                  adr_i,
  input  wire logic [31:0]                  dat_i,
  input  wire logic [3:0]                   sel_i,
  input  wire logic                         we_i,
  input  wire logic                         cyc_i,
  input  wire logic                         stb_i,
  output logic      [31:0]                  dat_o,
  output logic                              ack_o,
  input  wire logic                         master_mode_i,
  input  wire logic                         chip_select_mode_i,
  input  wire logic                         size_pins_enable_i,
  output pin_select_pkg::pin_fn_e [7:0]     port_e_fn_o,
  output logic      [7:5]                   port_f_address_o,
  output logic      [7:5]                   port_f_chip_select_o,
  output logic      [7:0]                   port_e_gpio_o,
  output logic      [7:5]                   port_f_gpio_o
);

  // single-bit select: a set bit hands the pin to its function, a clear bit leaves it on gpio
  function automatic pin_select_pkg::pin_fn_e bit_fn(input logic                    sel,
                                                     input pin_select_pkg::pin_fn_e on_fn);
    pin_select_pkg::pin_fn_e r;
    r = pin_select_pkg::fn_gpio;
    if (sel) begin
      r = on_fn;
    end
    return r;
  endfunction : bit_fn

  // two-bit field: both 0x codes mean gpio, so no code of the field is illegal
  function automatic pin_select_pkg::pin_fn_e field_fn(input logic [1:0] f);
    pin_select_pkg::pin_fn_e r;
    r = pin_select_pkg::fn_gpio;
    if (f == pin_select_pkg::field_alt) begin
      r = pin_select_pkg::fn_alternate;
    end else if (f == pin_select_pkg::field_pri) begin
      r = pin_select_pkg::fn_primary;
    end
    return r;
  endfunction : field_fn

  // lane merge: only enabled, writable bits change; reserved bits keep their zero
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [15:0] keep);
    logic [15:0] r;
    r = (old_v & ~keep) | (new_v & keep);
    return r;
  endfunction : lane_merge

  pin_select_pkg::sel_state_s    state_ff;
  pin_select_pkg::sel_state_s    nxt_state;
  pin_select_pkg::pin_fn_e [7:0] pin_fn;
  logic [15:0]                   e_keep;
  logic [15:0]                   f_keep;
  logic [15:0]                   f_merge;
  logic                          req;
  logic                          hit_e;
  logic                          hit_f;

  // byte lane 0 carries bits 7..0 and lane 1 bits 15..8 of a register
  assign e_keep = {{8{sel_i[1]}}, {8{sel_i[0]}}} & pin_select_pkg::pe_write_mask;
  assign f_keep = {8'h00, {8{sel_i[0]}} & pin_select_pkg::pf_write_mask};
  assign req    = cyc_i && stb_i && !state_ff.ack;
  assign hit_e  = (adr_i == pin_select_pkg::port_e_addr);
  assign hit_f  = (adr_i == pin_select_pkg::port_f_addr);

  always_comb begin
    nxt_state     = state_ff;
    nxt_state.ack = 1'b0;
    pin_fn        = state_ff.port_e_fn;
    f_merge       = lane_merge({8'h00, state_ff.port_f_function_select},
                               {8'h00, dat_i[7:0]},
                               f_keep);

    // master_mode_i is taken one edge after release, when the latched value has settled; the other mode inputs act at every edge
    nxt_state.cfg_done = 1'b1;
    if (!state_ff.cfg_done) begin
      if (master_mode_i) begin
        nxt_state.port_e_function_select = pin_select_pkg::pe_reset_master;
        nxt_state.port_f_function_select = pin_select_pkg::pf_reset_master;
      end else begin
        nxt_state.port_e_function_select = pin_select_pkg::pe_reset_single;
        nxt_state.port_f_function_select = pin_select_pkg::pf_reset_single;
      end
    end else if (req) begin
      // every access is acked so a stray address cannot hang the bus; unmapped reads give zero
      nxt_state.ack   = 1'b1;
      nxt_state.rdata = '0;
      if (hit_e) begin
        nxt_state.rdata = {16'h0000, state_ff.port_e_function_select};
        if (we_i) begin
          nxt_state.port_e_function_select = lane_merge(state_ff.port_e_function_select,
                                                        dat_i[15:0],
                                                        e_keep);
        end
      end else if (hit_f) begin
        nxt_state.rdata = {24'h000000, state_ff.port_f_function_select};
        if (we_i) begin
          nxt_state.port_f_function_select = f_merge[7:0];
        end
      end
    end

    // pins decode the registered selects, so a pin moves one edge after its write
    pin_fn[7] = bit_fn(state_ff.port_e_function_select[pin_select_pkg::pe_e7_bit],
                       pin_select_pkg::fn_primary);
    pin_fn[6] = bit_fn(state_ff.port_e_function_select[pin_select_pkg::pe_e6_bit],
                       pin_select_pkg::fn_primary);
    pin_fn[5] = bit_fn(state_ff.port_e_function_select[pin_select_pkg::pe_e5_bit],
                       pin_select_pkg::fn_primary);
    pin_fn[4] = bit_fn(state_ff.port_e_function_select[pin_select_pkg::pe_e4_bit],
                       pin_select_pkg::fn_primary);
    pin_fn[3] = bit_fn(state_ff.port_e_function_select[pin_select_pkg::pe_e3_bit],
                       pin_select_pkg::fn_alternate);
    pin_fn[2] = bit_fn(state_ff.port_e_function_select[pin_select_pkg::pe_e2_bit],
                       pin_select_pkg::fn_alternate);
    // the size functions belong to the configuration bit alone and win over the register
    if (size_pins_enable_i) begin
      pin_fn[3] = pin_select_pkg::fn_size;
      pin_fn[2] = pin_select_pkg::fn_size;
    end
    pin_fn[1] = field_fn(state_ff.port_e_function_select[pin_select_pkg::pe_e1_lsb +: 2]);
    pin_fn[0] = field_fn(state_ff.port_e_function_select[pin_select_pkg::pe_e0_lsb +: 2]);
    nxt_state.port_e_fn = pin_fn;

    // a gpio pin is handed to the port data logic in the same edge as its function code
    for (int k = 0; k < 8; k++) begin
      nxt_state.e_gpio[k] = (pin_fn[k] == pin_select_pkg::fn_gpio);
    end

    // the address/chip-select choice is a level; changing it moves the pins one edge later
    for (int i = pin_select_pkg::pf_f5_bit; i <= pin_select_pkg::pf_f7_bit; i++) begin
      nxt_state.f_addr[i] = state_ff.port_f_function_select[i] && !chip_select_mode_i;
      nxt_state.f_cs[i]   = state_ff.port_f_function_select[i] && chip_select_mode_i;
      nxt_state.f_gpio[i] = !state_ff.port_f_function_select[i];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign port_e_fn_o          = state_ff.port_e_fn;
  assign port_f_address_o     = state_ff.f_addr;
  assign port_f_chip_select_o = state_ff.f_cs;
  assign port_e_gpio_o        = state_ff.e_gpio;
  assign port_f_gpio_o        = state_ff.f_gpio;
  assign ack_o                = state_ff.ack;
  assign dat_o                = state_ff.rdata;

endmodule : port_e_f_pin_function_select

// ---- pin_select_checker.sv ----
`timescale 1ns/10ps
module pin_select_checker (
  input wire logic                          clk_i,
  input wire logic                          rst_i,
  input wire logic [25:0]                   adr_i,
  input wire logic                          we_i,
  input wire logic                          cyc_i,
  input wire logic                          stb_i,
  input wire logic [31:0]                   dat_o,
  input wire logic                          ack_o,
  input wire logic                          chip_select_mode_i,
  input wire logic                          size_pins_enable_i,
  input wire pin_select_pkg::pin_fn_e [7:0] port_e_fn_o,
  input wire logic [7:5]                    port_f_address_o,
  input wire logic [7:5]                    port_f_chip_select_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_cycle: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not acked");
  a_ack_has_cause: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
  a_pe_reserved_zero: assert property (ack_o && !$past(we_i) && $past(adr_i) == pin_select_pkg::port_e_addr
    |-> (dat_o & ~{16'h0000, pin_select_pkg::pe_write_mask}) == 32'h0) else $error("port e reserved bit set");
  a_pf_reserved_zero: assert property (ack_o && !$past(we_i) && $past(adr_i) == pin_select_pkg::port_f_addr
    |-> (dat_o & ~{24'h0, pin_select_pkg::pf_write_mask}) == 32'h0) else $error("port f reserved bit set");
  a_unmapped_zero: assert property (ack_o && !$past(we_i) && $past(adr_i) != pin_select_pkg::port_e_addr
    && $past(adr_i) != pin_select_pkg::port_f_addr |-> dat_o == 32'h0) else $error("unmapped read not zero");
  a_size_forces: assert property (size_pins_enable_i && $past(size_pins_enable_i) && !$past(rst_i)
    |=> port_e_fn_o[3] == pin_select_pkg::fn_size && port_e_fn_o[2] == pin_select_pkg::fn_size) else $error("size");
  a_cs_no_addr: assert property (chip_select_mode_i |=> port_f_address_o == 3'h0) else $error("address in cs mode");
  a_addr_no_cs: assert property (!chip_select_mode_i |=> port_f_chip_select_o == 3'h0) else $error("cs in addr mode");
endmodule : pin_select_checker

bind port_e_f_pin_function_select pin_select_checker i_chk (.*);

// ---- port_e_f_pin_function_select_bench.sv ----
`timescale 1ns/10ps
module port_e_f_pin_function_select_bench;
  logic                          clk_i, rst_i, we_i, cyc_i, stb_i, ack_o;
  logic                          master_mode_i, chip_select_mode_i, size_pins_enable_i;
  logic [25:0]                   adr_i;
  logic [31:0]                   dat_i, dat_o, rd;
  logic [3:0]                    sel_i;
  logic [7:5]                    port_f_address_o, port_f_chip_select_o, port_f_gpio_o;
  logic [7:0]                    port_e_gpio_o;
  pin_select_pkg::pin_fn_e [7:0] port_e_fn_o;
  int                            num_errors = 0;
  int                            compares = 0;
  localparam logic [25:0] pe = pin_select_pkg::port_e_addr;
  localparam logic [25:0] pf = pin_select_pkg::port_f_addr;
  port_e_f_pin_function_select i_dut (.*);
  always #4 clk_i = ~clk_i;
  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // holds the whole request until ack is sampled, then drops cyc and stb and returns at once
  task automatic wb(input logic [25:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int n = 0;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, s};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    if (n >= 20) begin
      num_errors++;
      $display("[ERR] %0t bus request not acknowledged", $time);
      end_sim();
    end
  endtask : wb
  function automatic logic [15:0] fn_exp(input logic [15:0] r, input logic sz);
    logic [15:0] f;
    for (int i = 0; i < 6; i++) f[15-2*i -: 2] = r[14-2*i] ? (i > 3 ? 2'h2 : 2'h1) : 2'h0;
    f[3:2] = r[3] ? (r[2] ? 2'h1 : 2'h2) : 2'h0;
    f[1:0] = r[1] ? (r[0] ? 2'h1 : 2'h2) : 2'h0;
    if (sz) f[7:4] = 4'hf;
    return f;
  endfunction : fn_exp
  task automatic do_reset(input logic m);
    master_mode_i <= m;
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : do_reset
  // write port e, read back, then let the pins settle
  task automatic pe_set(input logic [15:0] v, input logic sz);
    size_pins_enable_i <= sz;
    wb(pe, 1'b1, {16'hffff, v}, 4'h3);
    wb(pe, 1'b0, 32'h0, 4'h3);
    chk(rd, {16'h0, v & 16'h555f});
    repeat (2) @(posedge clk_i);
    chk({16'h0, port_e_fn_o}, {16'h0, fn_exp(v & 16'h555f, sz)});
  endtask : pe_set
  task automatic t_reset(input logic m);
    do_reset(m);
    wb(pe, 1'b0, 32'h0, 4'h3);
    chk(rd, m ? 32'h555f : 32'h0);
    wb(pf, 1'b0, 32'h0, 4'h1);
    chk(rd, m ? 32'he0 : 32'h0);
    chk({16'h0, port_e_fn_o}, {16'h0, fn_exp(m ? 16'h555f : 16'h0, 1'b0)});
  endtask : t_reset
  task automatic t_port_e();
    for (int v = 0; v < 4; v++) pe_set(16'h5550 | (16'(v) * 16'h5), 1'b0);
    pe_set(16'hffff, 1'b1);
    pe_set(16'h0000, 1'b0);
    chk({24'h0, port_e_gpio_o}, 32'hff);
  endtask : t_port_e
  task automatic t_port_f();
    wb(pf, 1'b1, 32'hff, 4'h1);
    wb(pf, 1'b0, 32'h0, 4'h1);
    chk(rd, 32'he0);
    for (int c = 0; c < 2; c++) begin
      chip_select_mode_i <= c[0];
      repeat (2) @(posedge clk_i);
      chk({port_f_address_o, port_f_chip_select_o}, c ? 32'h07 : 32'h38);
    end
    wb(pf, 1'b1, 32'h0, 4'h1);
    wb(26'h400150, 1'b1, 32'hffff, 4'hf);
    wb(26'h400150, 1'b0, 32'h0, 4'hf);
    chk(rd, 32'h0);
    repeat (2) @(posedge clk_i);
    chk({port_f_gpio_o, port_f_address_o, port_f_chip_select_o}, 32'h1c0);
  endtask : t_port_f
  initial begin
    {clk_i, we_i, cyc_i, stb_i, chip_select_mode_i, size_pins_enable_i} = 6'h0;
    {adr_i, dat_i, sel_i} = '0;
    t_reset(1'b1);
    t_port_e();
    t_port_f();
    t_reset(1'b0);
    end_sim();
  end
endmodule : port_e_f_pin_function_select_bench
